// ---- verilog/pfb_pkg.sv ----
// package: constants and types for the program flow branch unit
package pfb_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam logic [15:0] IP_RESET = 16'h0000;
    localparam logic [15:0] LC_RESET = 16'h0000;
    localparam logic [15:0] IP_STEP = 16'h0001;
    localparam logic [15:0] LC_STEP = 16'h0001;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    // processor_status_flags bit positions
    localparam int unsigned PSF_EQ = 0;
    localparam int unsigned PSF_CY = 1;
    localparam int unsigned PSF_OV = 2;
    localparam int unsigned PSF_S = 6;
    localparam int unsigned PSF_Z = 7;
    localparam int unsigned ACC_MSB = 15;

    typedef enum logic [3:0] {
        PFB_OP_NOP,
        PFB_OP_ADD,
        PFB_OP_ADDC,
        PFB_OP_SUB,
        PFB_OP_SUBB,
        PFB_OP_CMP,
        PFB_OP_JUMP,
        PFB_OP_CALL,
        PFB_OP_RET,
        PFB_OP_RETI,
        PFB_OP_DJNZ,
        PFB_OP_WR_LC
    } pfb_op_e;

    typedef enum logic [2:0] {
        PFB_CC_ALWAYS,
        PFB_CC_C,
        PFB_CC_NC,
        PFB_CC_Z,
        PFB_CC_NZ,
        PFB_CC_S,
        PFB_CC_E,
        PFB_CC_NE
    } pfb_cond_e;

    typedef enum logic [1:0] {
        PFB_TGT_REL8,
        PFB_TGT_IMM16,
        PFB_TGT_REG16,
        PFB_TGT_REG8
    } pfb_tgt_e;

    typedef struct packed {
        logic [15:0] ip;
        logic [15:0] ip_inc;
        logic [15:0] lc0;
        logic [15:0] lc1;
        logic ovf;
        logic eq;
        logic in_service_flag;
    } pfb_state_s;

endpackage : pfb_pkg

// ---- verilog/pfb_target.sv ----
// branch target formation from the four operand forms
`timescale 1ns/1ns
`default_nettype none
module pfb_target
    import pfb_pkg::*;
(
    input wire pfb_tgt_e kind_i,
    input wire logic [7:0] imm8_i,
    input wire logic [15:0] imm16_i,
    input wire logic [15:0] src16_i,
    input wire logic [7:0] src8_i,
    input wire logic [7:0] high_byte_prefix_i,
    input wire logic [15:0] ip_inc_i,
    output logic [15:0] target_o
);

    always_comb begin
        unique case (kind_i)
            PFB_TGT_REL8: target_o = ip_inc_i + {{8{imm8_i[7]}}, imm8_i}; // [RULE4] [RULE21]
            PFB_TGT_IMM16: target_o = imm16_i; // [RULE5]
            PFB_TGT_REG16: target_o = src16_i; // [RULE5]
            PFB_TGT_REG8: target_o = {high_byte_prefix_i, src8_i}; // [RULE6] [RULE13]
        endcase
    end

endmodule : pfb_target
`default_nettype wire

// ---- verilog/pfb_branch_unit.sv ----
// program flow branch unit: ip, loop counters, branch, call, return, status flags
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// (RULE1) add/sub family sets overflow to carry-out xor carry-in of the top bit
// (RULE2) overflow changes only on add, addc, sub, subb; holds otherwise
// (RULE3) reading the instruction pointer gives current instruction address plus one
// (RULE4) relative jumps use a signed 8-bit offset, -128 to +127 words
// (RULE5) absolute jumps take 16-bit immediate, 16-bit register or 8-bit register
// (RULE6) 8-bit sourced targets use the prefix as high byte
// (RULE7) conditional jumps branch on C, NC, Z, NZ, S, E, NE, else fall through
// (RULE8) jump on equal / not equal accept immediate targets only
// (RULE9) call takes jump targets and pushes the next sequential address first
// (RULE10) return pops the saved address; a separate exit leaves interrupt handlers
// (RULE11) loop instruction decrements its counter, branches while result is nonzero
// (RULE12) two independent 16-bit loop counters, selected by the loop instruction
// (RULE13) loop target is relative 8-bit or prefix high byte with 8-bit low byte
// (RULE14) software may preload a 16-bit register with the loop address for speed
// (RULE15) conditional return pops when true; otherwise stack and pointer unchanged
// (RULE16) conditional returns support carry set/clear, zero set/clear and sign set
// (RULE17) interrupt exit pops the return address and clears the in-service flag
// (RULE18) zero flag is one exactly when the active accumulator is all zeros
// (RULE19) sign flag mirrors bit 15 of the active accumulator
// (RULE20) compare sets equals when source matches accumulator, clears it otherwise
// (RULE21) relative target is incremented pointer plus sign-extended offset
module pfb_branch_unit
    import pfb_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic op_valid_i,
    input wire pfb_op_e op_i,
    input wire pfb_cond_e cond_i,
    input wire pfb_tgt_e tgt_kind_i,
    input wire logic lc_sel_i,
    input wire logic [7:0] imm8_i,
    input wire logic [15:0] imm16_i,
    input wire logic [15:0] src16_i,
    input wire logic [7:0] src8_i,
    input wire logic [7:0] high_byte_prefix_i,
    input wire logic [15:0] acc_i,
    input wire logic carry_i,
    input wire logic alu_carry_in_msb_i,
    input wire logic alu_carry_out_msb_i,
    input wire logic int_entry_i,
    input wire logic [15:0] int_vector_i,
    input wire logic [15:0] stack_rdata_i,
    output logic [15:0] instruction_pointer_o,
    output logic [15:0] ip_read_o,
    output logic [15:0] loop_count_zero_o,
    output logic [15:0] loop_count_one_o,
    output logic [7:0] processor_status_flags_o,
    output logic in_service_flag_o,
    output logic stack_push_o,
    output logic [15:0] stack_wdata_o,
    output logic stack_pop_o,
    output logic illegal_target_o
);

    // ========================================================
    // condition decode, shared by jumps and returns
    function automatic logic cond_holds(input pfb_cond_e c, input logic cy, input logic z,
                                        input logic s, input logic e);
        logic r;
        unique case (c)
            PFB_CC_ALWAYS: r = 1'b1;
            PFB_CC_C: r = cy;
            PFB_CC_NC: r = !cy;
            PFB_CC_Z: r = z;
            PFB_CC_NZ: r = !z;
            PFB_CC_S: r = s;
            PFB_CC_E: r = e;
            PFB_CC_NE: r = !e;
        endcase
        return r;
    endfunction : cond_holds

    // ========================================================
    // state and flags
    pfb_state_s st;
    pfb_state_s next_st;
    logic [15:0] target;
    logic flag_z;
    logic flag_s;
    logic cond_ok;
    logic imm_only_bad;
    logic [15:0] lc_dec;
    logic [15:0] jmp_to;

    assign flag_z = (acc_i == ZERO_WORD); // [RULE18]
    assign flag_s = acc_i[ACC_MSB]; // [RULE19]
    assign cond_ok = cond_holds(cond_i, carry_i, flag_z, flag_s, st.eq);
    // equals conditions never take a register target
    assign imm_only_bad = (cond_i == PFB_CC_E || cond_i == PFB_CC_NE)
                          && (tgt_kind_i == PFB_TGT_REG16 || tgt_kind_i == PFB_TGT_REG8); // [RULE8]
    assign lc_dec = (lc_sel_i ? st.lc1 : st.lc0) - LC_STEP; // [RULE11]

    pfb_target u_target (
        .kind_i(tgt_kind_i),
        .imm8_i(imm8_i),
        .imm16_i(imm16_i),
        .src16_i(src16_i),
        .src8_i(src8_i),
        .high_byte_prefix_i(high_byte_prefix_i),
        .ip_inc_i(st.ip_inc),
        .target_o(target)
    );

    // ========================================================
    // next state
    always_comb begin
        next_st = st;
        stack_push_o = 1'b0;
        stack_pop_o = 1'b0;
        illegal_target_o = 1'b0;
        jmp_to = st.ip_inc;
        if (int_entry_i) begin
            // interrupt entry preempts: current instruction is retried on return
            stack_push_o = 1'b1;
            jmp_to = int_vector_i;
            next_st.in_service_flag = 1'b1;
        end else if (op_valid_i) begin
            unique case (op_i)
                PFB_OP_ADD, PFB_OP_ADDC, PFB_OP_SUB, PFB_OP_SUBB: begin
                    next_st.ovf = alu_carry_in_msb_i ^ alu_carry_out_msb_i; // [RULE1] [RULE2]
                end
                PFB_OP_CMP: begin
                    next_st.eq = (src16_i == acc_i); // [RULE20]
                end
                PFB_OP_JUMP: begin
                    illegal_target_o = imm_only_bad; // [RULE8]
                    if (cond_ok && !imm_only_bad) begin
                        jmp_to = target; // [RULE7]
                    end
                end
                PFB_OP_CALL: begin
                    stack_push_o = 1'b1; // [RULE9]
                    jmp_to = target;
                end
                PFB_OP_RET, PFB_OP_RETI: begin
                    // returns also honour the E and NE codes, beyond the five listed
                    if (cond_ok) begin
                        stack_pop_o = 1'b1; // [RULE10] [RULE15] [RULE16]
                        jmp_to = stack_rdata_i;
                        if (op_i == PFB_OP_RETI) begin
                            next_st.in_service_flag = 1'b0; // [RULE17]
                        end
                    end
                end
                PFB_OP_DJNZ: begin
                    if (lc_sel_i) begin
                        next_st.lc1 = lc_dec; // [RULE12]
                    end else begin
                        next_st.lc0 = lc_dec; // [RULE12]
                    end
                    if (lc_dec != ZERO_WORD) begin
                        jmp_to = target; // [RULE11] [RULE13]
                    end
                end
                PFB_OP_WR_LC: begin
                    if (lc_sel_i) begin
                        next_st.lc1 = src16_i;
                    end else begin
                        next_st.lc0 = src16_i;
                    end
                end
                PFB_OP_NOP: begin
                end
                default: begin
                end
            endcase
        end
        if (int_entry_i || op_valid_i) begin
            next_st.ip = jmp_to;
            next_st.ip_inc = jmp_to + IP_STEP; // [RULE3]
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '{ip: IP_RESET, ip_inc: IP_RESET + IP_STEP, lc0: LC_RESET, lc1: LC_RESET,
                    ovf: 1'b0, eq: 1'b0, in_service_flag: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ========================================================
    // outputs
    assign instruction_pointer_o = st.ip;
    assign ip_read_o = st.ip_inc; // [RULE3]
    assign stack_wdata_o = int_entry_i ? st.ip : st.ip_inc; // [RULE9]
    assign loop_count_zero_o = st.lc0;
    assign loop_count_one_o = st.lc1;
    assign in_service_flag_o = st.in_service_flag;
    always_comb begin
        processor_status_flags_o = 8'h00;
        processor_status_flags_o[PSF_Z] = flag_z;
        processor_status_flags_o[PSF_S] = flag_s;
        processor_status_flags_o[PSF_OV] = st.ovf;
        processor_status_flags_o[PSF_CY] = carry_i;
        processor_status_flags_o[PSF_EQ] = st.eq;
    end

    // ========================================================
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    logic arith;
    assign arith = op_valid_i && !int_entry_i && (op_i == PFB_OP_ADD || op_i == PFB_OP_ADDC
                   || op_i == PFB_OP_SUB || op_i == PFB_OP_SUBB);

    property p_ovf_set;
        arith |=> st.ovf == $past(alu_carry_in_msb_i ^ alu_carry_out_msb_i);
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow wrong after add/sub"); // [RULE1]

    property p_ovf_hold;
        !arith |=> $stable(st.ovf);
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow moved"); // [RULE2]

    property p_ip_read;
        ip_read_o == instruction_pointer_o + IP_STEP;
    endproperty
    a_ip_read: assert property (p_ip_read) else $error("ip read not ip plus one"); // [RULE3]

    property p_rel_jump;
        op_valid_i && !int_entry_i && op_i == PFB_OP_JUMP && cond_i == PFB_CC_ALWAYS
            && tgt_kind_i == PFB_TGT_REL8
        |=> st.ip == $past(st.ip_inc) + {{8{$past(imm8_i[7])}}, $past(imm8_i)};
    endproperty
    a_rel_jump: assert property (p_rel_jump) else $error("relative target wrong"); // [RULE21]

    property p_reg8_jump;
        op_valid_i && !int_entry_i && op_i == PFB_OP_CALL && tgt_kind_i == PFB_TGT_REG8
        |=> st.ip == {$past(high_byte_prefix_i), $past(src8_i)};
    endproperty
    a_reg8_jump: assert property (p_reg8_jump) else $error("prefixed target wrong"); // [RULE6]

    property p_jump_fail;
        op_valid_i && !int_entry_i && op_i == PFB_OP_JUMP && (!cond_ok || imm_only_bad)
        |=> st.ip == $past(st.ip_inc);
    endproperty
    a_jump_fail: assert property (p_jump_fail) else $error("untaken jump moved ip"); // [RULE7]

    property p_call_push;
        op_valid_i && !int_entry_i && op_i == PFB_OP_CALL
        |-> stack_push_o && stack_wdata_o == st.ip_inc;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong"); // [RULE9]

    property p_ret_fail;
        op_valid_i && !int_entry_i && op_i == PFB_OP_RET && !cond_ok
        |-> !stack_pop_o ##1 st.ip == $past(st.ip_inc);
    endproperty
    a_ret_fail: assert property (p_ret_fail) else $error("failed return acted"); // [RULE15]

    property p_djnz_dec;
        op_valid_i && !int_entry_i && op_i == PFB_OP_DJNZ && !lc_sel_i
        |=> st.lc0 == $past(st.lc0) - LC_STEP && $stable(st.lc1);
    endproperty
    a_djnz_dec: assert property (p_djnz_dec) else $error("loop count not decremented"); // [RULE11]

    property p_reti_ins;
        op_valid_i && !int_entry_i && op_i == PFB_OP_RETI && cond_ok |=> !st.in_service_flag;
    endproperty
    a_reti_ins: assert property (p_reti_ins) else $error("in-service not cleared"); // [RULE17]

    c_call: cover property (op_valid_i && op_i == PFB_OP_CALL);
    c_djnz_taken: cover property (op_valid_i && op_i == PFB_OP_DJNZ && lc_dec != ZERO_WORD);
    c_reti: cover property (st.in_service_flag ##[1:20] !st.in_service_flag);

endmodule : pfb_branch_unit
`default_nettype wire

// ---- tb/pfb_stack_model.sv ----
// hardware stack model facing the branch unit
`timescale 1ns/1ns
`default_nettype none
module pfb_stack_model (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic push_i,
    input wire logic [15:0] wdata_i,
    input wire logic pop_i,
    output logic [15:0] rdata_o
);
    logic [15:0] mem[$];
    logic [15:0] top;
    logic [15:0] junk;
    logic empty;
    // empty stack shows a changing pattern so a stale word is never reused
    assign rdata_o = empty ? junk : top;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem.delete();
            junk <= 16'h5a3c;
        end else begin
            junk <= {junk[14:0], ~junk[15]};
            if (pop_i && mem.size() > 0) mem.pop_back();
            if (push_i) mem.push_back(wdata_i);
        end
        empty = (mem.size() == 0);
        top = empty ? 16'h0000 : mem[$];
    end
endmodule : pfb_stack_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the program flow branch unit
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import pfb_pkg::*;
    logic clock_i = 1'b0, rst_n_i = 1'b0, vld = 1'b0, sel = 1'b0, cy = 1'b0;
    logic cin = 1'b0, cout = 1'b0, irq = 1'b0;
    pfb_op_e op = PFB_OP_NOP;
    pfb_cond_e cc = PFB_CC_ALWAYS;
    pfb_tgt_e tk = PFB_TGT_REL8;
    logic [7:0] imm8 = 8'h00, src8 = 8'h00, pfx = 8'h00, flags;
    logic [15:0] imm16 = 16'h0000, src16 = 16'h0000, acc = 16'h0000, vec = 16'h0000;
    logic [15:0] rd, wd, ip, ipr, lc0, lc1, m_ip, m_lc0, m_lc1;
    logic push, pop, ill, in_service_flag, m_ovf, m_eq, m_ins;
    logic [15:0] mq[$];
    int errors = 0, num_checks = 0, cycles = 0;
    pfb_branch_unit i_pfb_branch_unit (.clock_i(clock_i), .rst_n_i(rst_n_i), .op_valid_i(vld),
        .op_i(op), .cond_i(cc), .tgt_kind_i(tk), .lc_sel_i(sel), .imm8_i(imm8), .imm16_i(imm16),
        .src16_i(src16), .src8_i(src8), .high_byte_prefix_i(pfx), .acc_i(acc), .carry_i(cy),
        .alu_carry_in_msb_i(cin), .alu_carry_out_msb_i(cout), .int_entry_i(irq),
        .int_vector_i(vec), .stack_rdata_i(rd), .instruction_pointer_o(ip), .ip_read_o(ipr),
        .loop_count_zero_o(lc0), .loop_count_one_o(lc1), .processor_status_flags_o(flags),
        .in_service_flag_o(in_service_flag), .stack_push_o(push), .stack_wdata_o(wd), .stack_pop_o(pop),
        .illegal_target_o(ill));
    pfb_stack_model i_pfb_stack_model (.clock_i(clock_i), .rst_n_i(rst_n_i), .push_i(push),
        .wdata_i(wd), .pop_i(pop), .rdata_o(rd));
    initial forever #4 clock_i = ~clock_i;
    // hang guard, well above the few thousand cycles the tests need
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 12000) begin
            errors++;
            test_done();
        end
    end
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit
    task automatic mreset();
        {m_ip, m_lc0, m_lc1, m_ovf, m_eq, m_ins} = '0;
        mq.delete();
    endtask : mreset
    // registered results, checked one cycle after the request edge
    task automatic sync();
        @(negedge clock_i);
        chk_word(ip, m_ip);
        chk_word(ipr, m_ip + 16'h0001);
        chk_word(lc0, m_lc0);
        chk_word(lc1, m_lc1);
        chk_bit(in_service_flag, m_ins);
    endtask : sync
    task automatic eval_op();
        logic [15:0] inc, tgt, nip;
        logic take, z, e_push, e_pop, e_ill;
        #1;
        inc = m_ip + 16'h0001;
        z = (acc == 16'h0000);
        case (tk)
            PFB_TGT_REL8: tgt = inc + {{8{imm8[7]}}, imm8};
            PFB_TGT_IMM16: tgt = imm16;
            PFB_TGT_REG16: tgt = src16;
            default: tgt = {pfx, src8};
        endcase
        case (cc)
            PFB_CC_ALWAYS: take = 1'b1;
            PFB_CC_C: take = cy;
            PFB_CC_NC: take = !cy;
            PFB_CC_Z: take = z;
            PFB_CC_NZ: take = !z;
            PFB_CC_S: take = acc[15];
            PFB_CC_E: take = m_eq;
            default: take = !m_eq;
        endcase
        {e_push, e_pop, e_ill} = 3'b000;
        nip = inc;
        chk_word({8'h00, flags}, {8'h00, z, acc[15], 3'b000, m_ovf, cy, m_eq});
        if (irq) begin
            e_push = 1'b1;
            chk_word(wd, m_ip);
            nip = vec;
            m_ins = 1'b1;
        end else if (!vld) begin
            nip = m_ip;
        end else begin
            case (op)
                PFB_OP_ADD, PFB_OP_ADDC, PFB_OP_SUB, PFB_OP_SUBB: m_ovf = cin ^ cout;
                PFB_OP_CMP: m_eq = (src16 == acc);
                PFB_OP_JUMP: begin
                    if ((cc == PFB_CC_E || cc == PFB_CC_NE) && tk[1]) e_ill = 1'b1;
                    else if (take) nip = tgt;
                end
                PFB_OP_CALL: begin
                    e_push = 1'b1;
                    chk_word(wd, inc);
                    nip = tgt;
                end
                PFB_OP_RET, PFB_OP_RETI: if (take) begin
                    e_pop = 1'b1;
                    nip = mq[$];
                    if (op == PFB_OP_RETI) m_ins = 1'b0;
                end
                PFB_OP_DJNZ: begin
                    if (sel) m_lc1 = m_lc1 - 16'h0001;
                    else m_lc0 = m_lc0 - 16'h0001;
                    if ((sel ? m_lc1 : m_lc0) != 16'h0000) nip = tgt;
                end
                PFB_OP_WR_LC: if (sel) m_lc1 = src16; else m_lc0 = src16;
                default: ;
            endcase
        end
        chk_bit(push, e_push);
        chk_bit(pop, e_pop);
        chk_bit(ill, e_ill);
        if (e_pop) void'(mq.pop_back());
        if (e_push) mq.push_back(irq ? m_ip : inc);
        m_ip = nip;
    endtask : eval_op
    task automatic go(input pfb_op_e o, input pfb_cond_e c, input pfb_tgt_e k, input logic [7:0] i8);
        sync();
        {vld, irq, imm8} = {1'b1, 1'b0, i8};
        op = o;
        cc = c;
        tk = k;
        eval_op();
    endtask : go
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    initial begin
        mreset();
        void'($urandom(31217));
        repeat (8) @(negedge clock_i);
        rst_n_i = 1'b1;
        // =====================================
        // directed: loop boundary, refused targets, call and interrupt
        src16 = 16'h0002;
        go(PFB_OP_WR_LC, PFB_CC_ALWAYS, PFB_TGT_REL8, 8'h00);
        // loop address preloaded in a 16-bit register, no prefix needed
        repeat (2) go(PFB_OP_DJNZ, PFB_CC_ALWAYS, PFB_TGT_REG16, 8'h00);
        go(PFB_OP_WR_LC, PFB_CC_ALWAYS, PFB_TGT_REL8, 8'h00);
        repeat (2) go(PFB_OP_DJNZ, PFB_CC_ALWAYS, PFB_TGT_REL8, 8'h80);
        go(PFB_OP_JUMP, PFB_CC_NE, PFB_TGT_REG16, 8'h00);
        go(PFB_OP_JUMP, PFB_CC_E, PFB_TGT_REG8, 8'h00);
        go(PFB_OP_CALL, PFB_CC_NC, PFB_TGT_REL8, 8'h7f);
        go(PFB_OP_RET, PFB_CC_ALWAYS, PFB_TGT_REL8, 8'h00);
        sync();
        {irq, vec} = {1'b1, 16'h4321};
        eval_op();
        go(PFB_OP_RETI, PFB_CC_ALWAYS, PFB_TGT_REL8, 8'h00);
        $display("directed done");
        // =====================================
        // random: every op, code and target kind, with a mid-run reset
        for (int n = 0; n < 4000; n++) begin
            sync();
            if (n == 2000) begin
                // idle the port first, or a stale op runs on the first edge after release
                {vld, irq} = 2'b00;
                rst_n_i = 1'b0;
                @(negedge clock_i);
                mreset();
                rst_n_i = 1'b1;
                sync();
            end
            vld = ($urandom_range(0, 7) != 0);
            irq = ($urandom_range(0, 40) == 0);
            op = pfb_op_e'($urandom_range(0, 11));
            if ((op == PFB_OP_RET || op == PFB_OP_RETI) && mq.size() == 0) op = PFB_OP_NOP;
            cc = pfb_cond_e'($urandom_range(0, 7));
            tk = pfb_tgt_e'($urandom_range(0, 3));
            {sel, cy, cin, cout} = 4'($urandom);
            {imm8, src8, pfx} = 24'($urandom);
            {imm16, vec} = $urandom;
            src16 = 16'($urandom) & ($urandom_range(0, 1) ? 16'h0003 : 16'hffff);
            acc = 16'($urandom) & ($urandom_range(0, 3) == 0 ? 16'h0000 : 16'hffff);
            eval_op();
        end
        sync();
        $display("random done");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
